//--- dv/cpu_seq_model.sv
// Sequencer stand-in that fetches the external vector
`timescale 1ns/1ps
module cpu_seq_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serviceOn,
  input wire logic cpuIrqRequest,
  output logic [15:0] cpuFetchAddr,
  output logic cpuFetchValid
);
  logic [3:0] stackCnt;
  // ==========================================================
  // One vector fetch per entry, then stacking time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stackCnt <= 4'h0;
      cpuFetchValid <= 1'b0;
      cpuFetchAddr <= 16'h0000;
    end else begin
      cpuFetchValid <= 1'b0;
      cpuFetchAddr <= 16'h0000; // Never the vector when idle
      if (stackCnt != 4'h0) begin
        stackCnt <= stackCnt - 4'h1;
      end else if (serviceOn && cpuIrqRequest) begin
        cpuFetchValid <= 1'b1;
        cpuFetchAddr <= ext_irq_pkg::VECTOR_HI_ADDR;
        stackCnt <= 4'hA;
      end
    end
  end
endmodule

//--- dv/eic_assertions.sv
// Port checker of the external interrupt combiner
`timescale 1ns/1ps
module eic_assertions #(
  parameter int PORT_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irqPin_n,
  input wire logic [PORT_WIDTH-1:0] portAPins,
  input wire logic [PORT_WIDTH-1:0] portCPins,
  input wire logic cpuFetchValid,
  input wire logic cpuIrqRequest,
  input wire logic pinLevelHigh
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic cpuWr;
  logic maskSeen;
  logic [3:0] rdCnt;
  logic [3:0] causeCnt;
  logic [3:0] clrCnt;
  assign take = hsel && hready && htrans == 2'h2;
  // ==========================================================
  // Windows after bus, pin and port activity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuWr <= 1'b0;
      maskSeen <= 1'b1;
      rdCnt <= 4'h0;
      causeCnt <= 4'h0;
      clrCnt <= 4'h0;
    end else begin
      // Mask as software last wrote it, landing with the data phase
      if (hready) begin
        cpuWr <= take && hwrite && haddr == ext_irq_pkg::CPU_SIDE_ADDR;
      end
      if (cpuWr) begin
        maskSeen <= hwdata[ext_irq_pkg::MASK_BIT];
      end
      rdCnt <= take ? 4'h3 : rdCnt - 4'(rdCnt != 4'h0);
      causeCnt <= (take || !irqPin_n || $changed(portAPins) ||
        $changed(portCPins)) ? 4'h8 : causeCnt - 4'(causeCnt != 4'h0);
      clrCnt <= (take || cpuFetchValid) ? 4'h6 : clrCnt - 4'(clrCnt != 4'h0);
    end
  end
  // Assertions
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not OKAY");
  property p_oneWait; !hreadyout |=> hreadyout; endproperty
  a_oneWait: assert property (p_oneWait) else $error("wait state too long");
  property p_rdStill; $changed(hrdata) |-> rdCnt != 4'h0; endproperty
  a_rdStill: assert property (p_rdStill) else $error("read data moved");
  property p_masked; maskSeen |=> !cpuIrqRequest; endproperty
  a_masked: assert property (p_masked) else $error("masked request");
  property p_pinHi; irqPin_n [*6] |-> pinLevelHigh; endproperty
  a_pinHi: assert property (p_pinHi) else $error("pin level not high");
  property p_pinLo; !irqPin_n [*6] |-> !pinLevelHigh; endproperty
  a_pinLo: assert property (p_pinLo) else $error("pin level not low");
  property p_pinSteady; $stable(irqPin_n) [*6] |-> $stable(pinLevelHigh); endproperty
  a_pinSteady: assert property (p_pinSteady) else $error("pin level moved");
  property p_rise; $rose(cpuIrqRequest) |-> causeCnt != 4'h0; endproperty
  a_rise: assert property (p_rise) else $error("request without cause");
  property p_fall; $fell(cpuIrqRequest) |-> clrCnt != 4'h0; endproperty
  a_fall: assert property (p_fall) else $error("request dropped alone");
endmodule

//--- dv/external_interrupt_combiner_bench.sv
// Self-checking bench of the external interrupt combiner
`timescale 1ns/1ps
module external_interrupt_combiner_bench;
  localparam logic [31:0] CS = ext_irq_pkg::CTRL_STATUS_BYTE;
  localparam logic [31:0] CPU = ext_irq_pkg::CPU_SIDE_ADDR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic irqPin_n = 1'b1;
  logic [7:0] portAPins = 8'hFF;
  logic [7:0] portAIn = 8'hFF;
  logic [7:0] portCPins = 8'hFF;
  logic lowPowerEntry = 1'b0;
  logic serviceOn = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic [15:0] fetchAddr;
  logic hreadyout, hresp, cpuIrqRequest, pinLevelHigh, fetchValid;
  int nErrors = 0;
  int totalChecks = 0;
  int cycles = 0;
  // ==========================================================
  // Design and partner
  external_interrupt_combiner u_external_interrupt_combiner (
    .clk(clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(ext_irq_pkg::HSIZE_WORD), .hsel(1'b1),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irqPin_n(irqPin_n),
    .portAPins(portAPins), .portAIsInput(portAIn), .portCPins(portCPins),
    .portCIsInput(8'hFF), .cpuFetchAddr(fetchAddr),
    .cpuFetchValid(fetchValid), .lowPowerEntry(lowPowerEntry),
    .cpuIrqRequest(cpuIrqRequest), .pinLevelHigh(pinLevelHigh));
  cpu_seq_model u_cpu_seq_model (.clk(clk), .rst_n(rst_n),
    .serviceOn(serviceOn), .cpuIrqRequest(cpuIrqRequest),
    .cpuFetchAddr(fetchAddr), .cpuFetchValid(fetchValid));
  // Bus cycle; read data taken at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [31:0] a,
      input logic [31:0] w);
    haddr <= a;
    hwrite <= wr;
    htrans <= ext_irq_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rdChk(input string what, input logic [31:0] a,
      input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(what, e, d);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic giveVerdict();
    $display("Checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Reset values and an unmapped place
  task automatic testReset();
    rdChk("ctrl", CS, 32'h02);
    rdChk("cpu", CPU, 32'h01);
    rdChk("hole", 32'h40, 32'h0);
  endtask
  // Port A edge with enable off, then on, writes and acknowledge
  task automatic testPortA();
    portAIn <= 8'hFE;
    portAPins <= 8'hFE;
    idle(8);
    rdChk("notInput", CS, 32'h02);
    portAIn <= 8'hFF;
    idle(8);
    rdChk("flagA", CS, 32'h42);
    xfer(1'b1, CPU, 32'h0);
    idle(2);
    chk("reqOff", 32'h0, 32'(cpuIrqRequest));
    xfer(1'b1, CS, 32'h06);
    idle(2);
    chk("reqOn", 32'h1, 32'(cpuIrqRequest));
    xfer(1'b1, CS, 32'hE6);
    portAPins <= 8'hFF;
    rdChk("roFlags", CS, 32'h46);
    xfer(1'b1, CS, 32'h16);
    rdChk("ackA", CS, 32'h06);
    chk("reqGone", 32'h0, 32'(cpuIrqRequest));
  endtask
  // Vector fetch clears the pin latch only
  task automatic testFetch();
    serviceOn <= 1'b1;
    irqPin_n <= 1'b0;
    portCPins <= 8'hEF;
    idle(16);
    rdChk("fetch", CS, 32'h26);
    chk("pinLow", 32'h0, 32'(pinLevelHigh));
    irqPin_n <= 1'b1;
    idle(8);
    chk("pinHigh", 32'h1, 32'(pinLevelHigh));
    serviceOn <= 1'b0;
    xfer(1'b1, CS, 32'h16);
    portCPins <= 8'hFF;
  endtask
  // Pin enable off blocks the flag; low power sets it back
  task automatic testPinEnable();
    xfer(1'b1, CS, 32'h04);
    irqPin_n <= 1'b0;
    idle(8);
    irqPin_n <= 1'b1;
    rdChk("pinOff", CS, 32'h04);
    lowPowerEntry <= 1'b1;
    @(posedge clk);
    lowPowerEntry <= 1'b0;
    rdChk("wake", CS, 32'h06);
  endtask
  // Level mode re-sets past an acknowledge; mask hides it
  task automatic testLevel();
    xfer(1'b1, CPU, 32'h02);
    irqPin_n <= 1'b0;
    idle(8);
    xfer(1'b1, CS, 32'h16);
    idle(8);
    rdChk("level", CS, 32'h86);
    chk("reqLvl", 32'h1, 32'(cpuIrqRequest));
    xfer(1'b1, CPU, 32'h03);
    idle(2);
    chk("masked", 32'h0, 32'(cpuIrqRequest));
    irqPin_n <= 1'b1;
    idle(6);
    xfer(1'b1, CS, 32'h16);
    rdChk("lvlClr", CS, 32'h06);
  endtask
  // Clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      giveVerdict();
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    testReset();
    testPortA();
    testFetch();
    testPinEnable();
    testLevel();
    giveVerdict();
  end
endmodule
bind external_interrupt_combiner eic_assertions #(
  .PORT_WIDTH(PORT_WIDTH)) u_eic_assertions (.clk(clk), .rst_n(rst_n),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hsel(hsel), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irqPin_n(irqPin_n),
  .portAPins(portAPins), .portCPins(portCPins),
  .cpuFetchValid(cpuFetchValid), .cpuIrqRequest(cpuIrqRequest),
  .pinLevelHigh(pinLevelHigh));

//--- hdl/ext_irq_pkg.sv
// Constants and carrier types of the external interrupt combiner
package ext_irq_pkg;
  // ==========================================================
  // Register map (register index, then byte addresses on the bus)
  localparam logic [31:0] CTRL_STATUS_ADDR = 32'h0000001F;
  localparam logic [31:0] CTRL_STATUS_BYTE = 32'h0000007C; // 4 x index
  localparam logic [31:0] CPU_SIDE_ADDR = 32'h00000080;
  // ==========================================================
  // Field positions of the control/status register
  localparam int PIN_ENABLE_BIT = 1;
  localparam int PORTA_ENABLE_BIT = 2;
  localparam int PORTC_ENABLE_BIT = 3;
  localparam int ACK_BIT = 4;
  localparam int PORTC_FLAG_BIT = 5;
  localparam int PORTA_FLAG_BIT = 6;
  localparam int PIN_FLAG_BIT = 7;
  // Field positions of the CPU-side control register
  localparam int MASK_BIT = 0;
  localparam int LEVEL_BIT = 1;
  // ==========================================================
  // Reset values
  localparam logic PIN_ENABLE_RST = 1'b1;
  localparam logic PORT_ENABLE_RST = 1'b0;
  localparam logic MASK_RST = 1'b1;
  localparam logic LEVEL_RST = 1'b0;
  // ==========================================================
  // Vector locations of the external request
  localparam logic [15:0] VECTOR_HI_ADDR = 16'h3FFA;
  localparam logic [15:0] VECTOR_LO_ADDR = 16'h3FFB;
  // AHB codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Pending latches and enables travel together
  typedef struct packed {
    logic pin;
    logic portA;
    logic portC;
  } source_t;
endpackage

//--- hdl/external_interrupt_combiner.sv
// External interrupt combiner with AHB-Lite register slave
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module external_interrupt_combiner #(
  parameter int PORT_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic irqPin_n,
  input wire logic [PORT_WIDTH-1:0] portAPins,
  input wire logic [PORT_WIDTH-1:0] portAIsInput,
  input wire logic [PORT_WIDTH-1:0] portCPins,
  input wire logic [PORT_WIDTH-1:0] portCIsInput,
  input wire logic [15:0] cpuFetchAddr,
  input wire logic cpuFetchValid,
  input wire logic lowPowerEntry,
  output logic cpuIrqRequest,
  output logic pinLevelHigh
);
  // ==========================================================
  // Elaboration check
  if (PORT_WIDTH < 1 || PORT_WIDTH > 8) begin : gWidthCheck
    $error("PORT_WIDTH must be 1 to 8");
  end

  // Flag and acknowledge fields must sit in the byte-wide register
  if (ext_irq_pkg::PIN_FLAG_BIT > 7
    || ext_irq_pkg::PORTA_FLAG_BIT > 7
    || ext_irq_pkg::PORTC_FLAG_BIT > 7
    || ext_irq_pkg::ACK_BIT > 7) begin : gFieldCheck
    $error("control/status fields must lie in bits 0 to 7");
  end

  // ==========================================================
  // Input synchronisers (three stages, agreement of last two)
  logic portAAnd;
  logic portCAnd;
  logic pinStable;
  logic pinFall;
  logic portAFall;
  logic portCFall;

  // Non-inputs count as high so they never pull the AND low
  assign portAAnd = &(portAPins | ~portAIsInput);
  assign portCAnd = &(portCPins | ~portCIsInput);

  // Pin: asynchronous level, filtered before any edge is taken
  ext_irq_edge_sync u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(irqPin_n),
    .level(pinStable),
    .fall(pinFall)
  );

  // Port AND is formed before sync so one bit crosses, not eight
  ext_irq_edge_sync u_port_a_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(portAAnd),
    .level(),
    .fall(portAFall)
  );

  // Port C follows the same path as port A
  ext_irq_edge_sync u_port_c_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(portCAnd),
    .level(),
    .fall(portCFall)
  );

  // ==========================================================
  // AHB-Lite slave: capture address phase, act in data phase
  logic wrPending_reg;
  logic rdPending_reg;
  logic [31:0] addr_reg;
  logic accept;
  assign accept = hsel && hready && htrans == ext_irq_pkg::HTRANS_NONSEQ
    && hsize == ext_irq_pkg::HSIZE_WORD;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPending_reg <= 1'b0;
      rdPending_reg <= 1'b0;
      addr_reg <= 32'h00000000;
    end else if (hready) begin
      wrPending_reg <= accept && hwrite;
      rdPending_reg <= accept && !hwrite;
      addr_reg <= haddr;
    end
  end

  logic wrCtrl;
  logic wrCpu;
  logic ackWrite;
  // Address decode for the data-phase write
  always_comb begin
    wrCtrl = 1'b0;
    wrCpu = 1'b0;
    if (!wrPending_reg) begin
      wrCtrl = 1'b0;
    end else if (addr_reg == ext_irq_pkg::CTRL_STATUS_BYTE) begin
      wrCtrl = 1'b1;
    end else if (addr_reg == ext_irq_pkg::CPU_SIDE_ADDR) begin
      wrCpu = 1'b1;
    end
  end
  assign ackWrite = wrCtrl && hwdata[ext_irq_pkg::ACK_BIT];

  // ==========================================================
  // Enables and CPU-side configuration
  ext_irq_pkg::source_t enable_reg;
  logic cpuMask_reg;
  logic levelMode_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg.pin <= ext_irq_pkg::PIN_ENABLE_RST;
      enable_reg.portA <= ext_irq_pkg::PORT_ENABLE_RST;
      enable_reg.portC <= ext_irq_pkg::PORT_ENABLE_RST;
    end else begin
      if (wrCtrl) begin
        enable_reg.pin <= hwdata[ext_irq_pkg::PIN_ENABLE_BIT];
        enable_reg.portA <= hwdata[ext_irq_pkg::PORTA_ENABLE_BIT];
        enable_reg.portC <= hwdata[ext_irq_pkg::PORTC_ENABLE_BIT];
      end
      // Low-power entry forces pin wake-up; port enables left alone
      if (lowPowerEntry) begin
        enable_reg.pin <= 1'b1;
      end
    end
  end

  // Mask stands in for the CPU interrupt mask, set out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuMask_reg <= ext_irq_pkg::MASK_RST;
    end else if (wrCpu) begin
      cpuMask_reg <= hwdata[ext_irq_pkg::MASK_BIT];
    end
  end

  // Level option; a register here since no option byte is modelled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      levelMode_reg <= ext_irq_pkg::LEVEL_RST;
    end else if (wrCpu) begin
      levelMode_reg <= hwdata[ext_irq_pkg::LEVEL_BIT];
    end
  end

  // ==========================================================
  // Pending latches; set wins over every clear
  ext_irq_pkg::source_t pending_reg;
  logic vectorFetch;
  logic pinSet;
  assign vectorFetch = cpuFetchValid
    && cpuFetchAddr == ext_irq_pkg::VECTOR_HI_ADDR;
  assign pinSet = enable_reg.pin && (pinFall
    || (levelMode_reg && !pinStable));

  // Register writes never touch flags, only acknowledge does
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= '0;
    end else begin
      if (pinSet) begin
        pending_reg.pin <= 1'b1;
      end else if (ackWrite || vectorFetch) begin
        pending_reg.pin <= 1'b0;
      end
      if (portAFall) begin
        pending_reg.portA <= 1'b1;
      end else if (ackWrite) begin
        pending_reg.portA <= 1'b0;
      end
      if (portCFall) begin
        pending_reg.portC <= 1'b1;
      end else if (ackWrite) begin
        pending_reg.portC <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Combined request and pin level, registered outputs
  logic requestNext;
  assign requestNext = !cpuMask_reg
    && |(pending_reg & enable_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuIrqRequest <= 1'b0;
      pinLevelHigh <= 1'b1;
    end else begin
      cpuIrqRequest <= requestNext;
      pinLevelHigh <= pinStable;
    end
  end

  // ==========================================================
  // Read data, answered after one wait state
  logic [31:0] readNext;
  always_comb begin
    readNext = 32'h00000000;
    if (addr_reg == ext_irq_pkg::CTRL_STATUS_BYTE) begin
      readNext[ext_irq_pkg::PIN_FLAG_BIT] = pending_reg.pin;
      readNext[ext_irq_pkg::PORTA_FLAG_BIT] = pending_reg.portA;
      readNext[ext_irq_pkg::PORTC_FLAG_BIT] = pending_reg.portC;
      readNext[ext_irq_pkg::ACK_BIT] = 1'b0;
      readNext[ext_irq_pkg::PORTC_ENABLE_BIT] = enable_reg.portC;
      readNext[ext_irq_pkg::PORTA_ENABLE_BIT] = enable_reg.portA;
      readNext[ext_irq_pkg::PIN_ENABLE_BIT] = enable_reg.pin;
    end else if (addr_reg == ext_irq_pkg::CPU_SIDE_ADDR) begin
      readNext[ext_irq_pkg::MASK_BIT] = cpuMask_reg;
      readNext[ext_irq_pkg::LEVEL_BIT] = levelMode_reg;
    end
  end

  // One wait state per read, so a write just before lands first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
    end else if (accept && !hwrite) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // Read data loaded in the wait state, held until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (rdPending_reg && !hreadyout) begin
      hrdata <= readNext;
    end
  end

  // Every transfer is answered OKAY; refused ones simply do nothing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end
endmodule

// ==========================================================
// Three-stage synchroniser with agreement filter and fall pulse
module ext_irq_edge_sync #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic level,
  output logic fall
);
  logic [2:0] stage_reg;
  logic level_reg;
  logic agree;

  // Stages preset to the idle level, so reset makes no false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= {3{IDLE_LEVEL}};
    end else begin
      stage_reg <= {stage_reg[1:0], din};
    end
  end

  // A change counts only once stages two and three agree
  assign agree = stage_reg[1] == stage_reg[2];

  // Accepted level; a one-cycle glitch never reaches it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= IDLE_LEVEL;
    end else if (agree) begin
      level_reg <= stage_reg[2];
    end
  end

  assign level = level_reg;
  // One pulse per accepted high-to-low change
  assign fall = level_reg && agree && !stage_reg[2];
endmodule
